// ==== rtl/jcbc_map.vh ====
`ifndef JCBC_MAP_VH
`define JCBC_MAP_VH
// register indices; byte address is four times the index
`define JCBC_IDX_CTRL 12'h0a00
`define JCBC_IDX_IRQ_EN 12'h0a04
`define JCBC_IDX_COLS 12'h0a06
`define JCBC_IDX_ROWS 12'h0a08
`define JCBC_IDX_Y_LO 12'h0a0a
`define JCBC_IDX_Y_HI 12'h0a0c
`define JCBC_IDX_B_LO 12'h0a0e
`define JCBC_IDX_B_HI 12'h0a10
`define JCBC_IDX_R_LO 12'h0a12
`define JCBC_IDX_R_HI 12'h0a14
`define JCBC_IDX_SLICES 12'h0a16
`define JCBC_IDX_Y_STRIDE 12'h0a18
`define JCBC_IDX_C_STRIDE 12'h0a1a
`define JCBC_IDX_WR_SLICES 12'h0a1c
`define JCBC_IDX_CB_LO 12'h0a1e
`define JCBC_IDX_CB_HI 12'h0a20
`define JCBC_IDX_SZ_LO 12'h0a22
`define JCBC_IDX_SZ_HI 12'h0a24
`define JCBC_IDX_AMT_LO 12'h0a26
`define JCBC_IDX_AMT_HI 12'h0a28
`define JCBC_IDX_SHARP1 12'h0a2a
`define JCBC_IDX_SHARP2 12'h0a2c
`define JCBC_IDX_LQ_FIRST 12'h0a2e
`define JCBC_IDX_LQ_LAST 12'h0a6c
`define JCBC_IDX_CQ_FIRST 12'h0a6e
`define JCBC_IDX_CQ_LAST 12'h0aac
`define JCBC_IDX_LAUNCH 12'h0aae
`define JCBC_IDX_STATE 12'h0ab0
`define JCBC_IDX_FLAGS 12'h0ab2
// field positions
`define JCBC_BIT_TRIG_SRC 3
`define JCBC_BIT_LAUNCH 8
`define JCBC_BIT_SOFT_RST 0
`define JCBC_BIT_DIR 0
`define JCBC_BIT_OCC 8
`define JCBC_BIT_CFULL 7
`define JCBC_BIT_CEMPTY 6
`define JCBC_BIT_PFULL 5
`define JCBC_BIT_PEMPTY 4
`define JCBC_BIT_SIZE 3
`define JCBC_BIT_FAULT 2
`define JCBC_BIT_ENC_DONE 1
`define JCBC_BIT_DEC_DONE 0
// field widths
`define JCBC_W_COLS 9
`define JCBC_W_ROWS 8
`define JCBC_W_BASE_HI 6
`define JCBC_W_SLICE 5
`define JCBC_W_STRIDE 11
`define JCBC_W_SIZE_HI 3
`define JCBC_W_FLAGS 9
`define JCBC_MAX_SLICES 5'h10
`define JCBC_RST16 16'h0000
`define JCBC_THR_LO 8
`define JCBC_THR_HI 9
`endif

// ==== rtl/jcbc_ctrl.v ====
`timescale 1ns/1ps
`default_nettype none
`include "jcbc_map.vh"
module jcbc_ctrl (
	// clock, reset, enable
	input wire pclk,
	input wire presetn,
	input wire pce,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [13:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// engine status
	input wire [3:0] eng_state,
	input wire [18:0] eng_code_valid,
	input wire eng_code_full,
	input wire eng_code_empty,
	input wire eng_pix_full,
	input wire eng_pix_empty,
	input wire eng_size_evt,
	input wire eng_fault_evt,
	input wire eng_enc_done_evt,
	input wire eng_dec_done_evt,
	input wire [4:0] eng_slices_seen,
	// quant table read port
	input wire qt_rd_chroma,
	input wire [5:0] qt_rd_addr,
	output reg [7:0] qt_rd_data,
	// configuration to engine
	output reg [8:0] luma_block_columns,
	output reg [7:0] luma_block_rows,
	output reg [21:0] luma_buffer_base,
	output reg [21:0] blue_chroma_buffer_base,
	output reg [21:0] red_chroma_buffer_base,
	output reg [4:0] line_buffer_slice_count,
	output reg [4:0] chroma_slice_count,
	output reg [10:0] line_buffer_stride,
	output reg [10:0] chroma_line_stride,
	output reg [4:0] written_slice_count,
	output reg [21:0] code_buffer_base,
	output reg [18:0] code_buffer_size,
	output reg [18:0] code_transfer_amount,
	output reg [15:0] sharpen_limit_first,
	output reg [15:0] sharpen_limit_second,
	output reg direction_select,
	output reg encode_trigger_source,
	output reg luma_from_isp,
	output reg code_written_by_engine,
	// commands and interrupt
	output reg codec_launch,
	output reg engine_soft_reset,
	output reg size_continue,
	output reg size_stop,
	output reg fault_continue,
	output reg fault_stop,
	output reg irq
);

	reg [3:0] ctrl_ff;
	reg [1:0] occ_sel_ff;
	reg [8:0] irq_en_ff;
	reg [8:0] flags_ff;
	reg [15:0] lq_mem [0:31];
	reg [15:0] cq_mem [0:31];
	reg [15:0] rd_val;
	reg rd_hit;
	reg [8:0] nxt_flags;
	reg [18:0] occ_limit;
	reg [15:0] qt_word;
	wire [11:0] idx;
	wire acc;
	wire wr;
	wire [15:0] wd;
	wire [4:0] lq_sel;
	wire [4:0] cq_sel;
	wire in_lq;
	wire in_cq;
	wire cmd_encode;
	wire [11:0] lq_off;
	wire [11:0] cq_off;
	wire aligned;
	wire [8:0] evt_pending;

	assign idx = paddr[13:2];
	// only the low half-word carries data
	assign wd = pwdata[15:0];
	// the setup cycle alone never touches state
	assign acc = psel & penable;
	// a misaligned access errors like an unmapped one and must not land anywhere
	assign aligned = (paddr[1:0] == 2'b00);
	// a write lands only at the edge where pready is seen high
	assign wr = pce & acc & pwrite & pready & aligned;
	// odd indices inside the table windows are holes and error
	assign lq_off = idx - `JCBC_IDX_LQ_FIRST;
	assign cq_off = idx - `JCBC_IDX_CQ_FIRST;
	assign lq_sel = lq_off[5:1];
	assign cq_sel = cq_off[5:1];
	assign in_lq = (idx >= `JCBC_IDX_LQ_FIRST) & (idx <= `JCBC_IDX_LQ_LAST) & ~lq_off[0];
	assign in_cq = (idx >= `JCBC_IDX_CQ_FIRST) & (idx <= `JCBC_IDX_CQ_LAST) & ~cq_off[0];
	assign cmd_encode = direction_select & encode_trigger_source;
	// irq is a level that follows the flags; clearing a flag drops it
	assign evt_pending = nxt_flags & irq_en_ff;

	// occupancy limit as a fraction of the code buffer
	// fractions round down, so a tiny buffer flags on any data at all
	always @* begin
		case (occ_sel_ff)
			2'b00: occ_limit = code_buffer_size >> 4;
			2'b01: occ_limit = code_buffer_size >> 3;
			2'b10: occ_limit = code_buffer_size >> 2;
			default: occ_limit = code_buffer_size >> 1;
		endcase
	end

	// read mux; reserved bits read zero
	always @* begin
		rd_val = `JCBC_RST16;
		rd_hit = 1'b1;
		if (in_lq) begin
			rd_val = lq_mem[lq_sel];
		end else if (in_cq) begin
			rd_val = cq_mem[cq_sel];
		end else begin
			case (idx)
				`JCBC_IDX_CTRL: rd_val = {12'h000, ctrl_ff};
				`JCBC_IDX_IRQ_EN: rd_val = {7'h00, irq_en_ff};
				`JCBC_IDX_COLS: rd_val = {7'h00, luma_block_columns};
				`JCBC_IDX_ROWS: rd_val = {8'h00, luma_block_rows};
				`JCBC_IDX_Y_LO: rd_val = luma_buffer_base[15:0];
				`JCBC_IDX_Y_HI: rd_val = {10'h000, luma_buffer_base[21:16]};
				`JCBC_IDX_B_LO: rd_val = blue_chroma_buffer_base[15:0];
				`JCBC_IDX_B_HI: rd_val = {10'h000, blue_chroma_buffer_base[21:16]};
				`JCBC_IDX_R_LO: rd_val = red_chroma_buffer_base[15:0];
				`JCBC_IDX_R_HI: rd_val = {10'h000, red_chroma_buffer_base[21:16]};
				`JCBC_IDX_SLICES: rd_val = {11'h000, line_buffer_slice_count};
				`JCBC_IDX_Y_STRIDE: rd_val = {5'h00, line_buffer_stride};
				`JCBC_IDX_C_STRIDE: rd_val = {5'h00, chroma_line_stride};
				`JCBC_IDX_WR_SLICES: rd_val = {11'h000, cmd_encode ? written_slice_count : eng_slices_seen};
				`JCBC_IDX_CB_LO: rd_val = code_buffer_base[15:0];
				`JCBC_IDX_CB_HI: rd_val = {10'h000, code_buffer_base[21:16]};
				`JCBC_IDX_SZ_LO: rd_val = code_buffer_size[15:0];
				// the threshold shares this word with the top bits of the size
				`JCBC_IDX_SZ_HI: rd_val = {6'h00, occ_sel_ff, 5'h00, code_buffer_size[18:16]};
				`JCBC_IDX_AMT_LO: rd_val = code_transfer_amount[15:0];
				`JCBC_IDX_AMT_HI: rd_val = {13'h0000, code_transfer_amount[18:16]};
				`JCBC_IDX_SHARP1: rd_val = sharpen_limit_first;
				`JCBC_IDX_SHARP2: rd_val = sharpen_limit_second;
				`JCBC_IDX_LAUNCH: rd_val = `JCBC_RST16;
				`JCBC_IDX_STATE: rd_val = {11'h000, eng_state, direction_select};
				`JCBC_IDX_FLAGS: rd_val = {7'h00, flags_ff};
				default: rd_hit = 1'b0;
			endcase
		end
	end

	// flag update: hardware set always beats a software clear
	always @* begin
		nxt_flags = flags_ff;
		// live buffer levels
		nxt_flags[`JCBC_BIT_CFULL] = eng_code_full;
		nxt_flags[`JCBC_BIT_CEMPTY] = eng_code_empty;
		nxt_flags[`JCBC_BIT_PFULL] = eng_pix_full;
		nxt_flags[`JCBC_BIT_PEMPTY] = eng_pix_empty;
		if (wr && idx == `JCBC_IDX_FLAGS) begin
			if (wd[`JCBC_BIT_OCC])
				nxt_flags[`JCBC_BIT_OCC] = 1'b0;
			if (flags_ff[`JCBC_BIT_SIZE])
				nxt_flags[`JCBC_BIT_SIZE] = 1'b0;
			if (flags_ff[`JCBC_BIT_FAULT])
				nxt_flags[`JCBC_BIT_FAULT] = 1'b0;
		end
		// done flags cover one operation
		if (wr && idx == `JCBC_IDX_LAUNCH && wd[`JCBC_BIT_LAUNCH]) begin
			nxt_flags[`JCBC_BIT_ENC_DONE] = 1'b0;
			nxt_flags[`JCBC_BIT_DEC_DONE] = 1'b0;
		end
		if (eng_code_valid > occ_limit)
			nxt_flags[`JCBC_BIT_OCC] = 1'b1;
		if (eng_size_evt)
			nxt_flags[`JCBC_BIT_SIZE] = 1'b1;
		if (eng_fault_evt)
			nxt_flags[`JCBC_BIT_FAULT] = 1'b1;
		if (eng_enc_done_evt)
			nxt_flags[`JCBC_BIT_ENC_DONE] = 1'b1;
		if (eng_dec_done_evt)
			nxt_flags[`JCBC_BIT_DEC_DONE] = 1'b1;
	end

	// quant table word for the engine side
	always @* begin
		qt_word = qt_rd_chroma ? cq_mem[qt_rd_addr[5:1]] : lq_mem[qt_rd_addr[5:1]];
	end

	// apb handshake: one wait state, data registered with pready
	// pce low stalls an access in place along with pready
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (pce) begin
			pready <= acc & ~pready;
			if (acc & ~pready) begin
				prdata <= pwrite ? 32'h0000_0000 : {16'h0000, rd_val};
				pslverr <= ~rd_hit | ~aligned;
			end
		end
	end

	// quant table storage, written in place, no reset
	always @(posedge pclk) begin
		if (wr && in_lq)
			lq_mem[lq_sel] <= wd;
		if (wr && in_cq)
			cq_mem[cq_sel] <= wd;
	end

	// even entry in the low byte, odd in the high byte
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			qt_rd_data <= 8'h00;
		end else if (pce) begin
			qt_rd_data <= qt_rd_addr[0] ? qt_word[15:8] : qt_word[7:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= 4'h0;
			occ_sel_ff <= 2'h0;
			irq_en_ff <= 9'h000;
			flags_ff <= 9'h000;
			luma_block_columns <= 9'h000;
			luma_block_rows <= 8'h00;
			luma_buffer_base <= 22'h00_0000;
			blue_chroma_buffer_base <= 22'h00_0000;
			red_chroma_buffer_base <= 22'h00_0000;
			line_buffer_slice_count <= 5'h00;
			chroma_slice_count <= 5'h00;
			line_buffer_stride <= 11'h000;
			chroma_line_stride <= 11'h000;
			written_slice_count <= 5'h00;
			code_buffer_base <= 22'h00_0000;
			code_buffer_size <= 19'h0_0000;
			code_transfer_amount <= 19'h0_0000;
			sharpen_limit_first <= `JCBC_RST16;
			sharpen_limit_second <= `JCBC_RST16;
			direction_select <= 1'b0;
			encode_trigger_source <= 1'b0;
			luma_from_isp <= 1'b0;
			code_written_by_engine <= 1'b0;
			codec_launch <= 1'b0;
			engine_soft_reset <= 1'b0;
			size_continue <= 1'b0;
			size_stop <= 1'b0;
			fault_continue <= 1'b0;
			fault_stop <= 1'b0;
			irq <= 1'b0;
		end else if (pce) begin
			flags_ff <= nxt_flags;
			irq <= |evt_pending;
			luma_from_isp <= direction_select & ~encode_trigger_source;
			code_written_by_engine <= direction_select;
			// an odd slice count rounds the chroma depth down
			chroma_slice_count <= line_buffer_slice_count >> 1;
			// command pulses last one cycle
			codec_launch <= 1'b0;
			engine_soft_reset <= 1'b0;
			size_continue <= 1'b0;
			size_stop <= 1'b0;
			fault_continue <= 1'b0;
			fault_stop <= 1'b0;
			if (wr) begin
				case (idx)
					`JCBC_IDX_CTRL: begin
						// bits 2:0 are kept for software only; nothing here reads them
						ctrl_ff <= wd[3:0];
						encode_trigger_source <= wd[`JCBC_BIT_TRIG_SRC];
					end
					`JCBC_IDX_IRQ_EN: irq_en_ff <= wd[`JCBC_W_FLAGS-1:0];
					`JCBC_IDX_COLS: luma_block_columns <= wd[`JCBC_W_COLS-1:0];
					`JCBC_IDX_ROWS: luma_block_rows <= wd[`JCBC_W_ROWS-1:0];
					`JCBC_IDX_Y_LO: luma_buffer_base[15:0] <= wd;
					`JCBC_IDX_Y_HI: luma_buffer_base[21:16] <= wd[`JCBC_W_BASE_HI-1:0];
					`JCBC_IDX_B_LO: blue_chroma_buffer_base[15:0] <= wd;
					`JCBC_IDX_B_HI: blue_chroma_buffer_base[21:16] <= wd[`JCBC_W_BASE_HI-1:0];
					`JCBC_IDX_R_LO: red_chroma_buffer_base[15:0] <= wd;
					`JCBC_IDX_R_HI: red_chroma_buffer_base[21:16] <= wd[`JCBC_W_BASE_HI-1:0];
					`JCBC_IDX_SLICES: begin
						// depth beyond sixteen slices is clamped
						if (wd[`JCBC_W_SLICE-1:0] > `JCBC_MAX_SLICES)
							line_buffer_slice_count <= `JCBC_MAX_SLICES;
						else
							line_buffer_slice_count <= wd[`JCBC_W_SLICE-1:0];
					end
					`JCBC_IDX_Y_STRIDE: line_buffer_stride <= wd[`JCBC_W_STRIDE-1:0];
					`JCBC_IDX_C_STRIDE: chroma_line_stride <= wd[`JCBC_W_STRIDE-1:0];
					`JCBC_IDX_WR_SLICES: begin
						// writes outside command encode are dropped, not queued
						if (cmd_encode)
							written_slice_count <= wd[`JCBC_W_SLICE-1:0];
					end
					`JCBC_IDX_CB_LO: code_buffer_base[15:0] <= wd;
					`JCBC_IDX_CB_HI: code_buffer_base[21:16] <= wd[`JCBC_W_BASE_HI-1:0];
					`JCBC_IDX_SZ_LO: code_buffer_size[15:0] <= wd;
					`JCBC_IDX_SZ_HI: begin
						code_buffer_size[18:16] <= wd[`JCBC_W_SIZE_HI-1:0];
						occ_sel_ff <= wd[`JCBC_THR_HI:`JCBC_THR_LO];
					end
					`JCBC_IDX_AMT_LO: code_transfer_amount[15:0] <= wd;
					`JCBC_IDX_AMT_HI: code_transfer_amount[18:16] <= wd[`JCBC_W_SIZE_HI-1:0];
					`JCBC_IDX_SHARP1: sharpen_limit_first <= wd;
					`JCBC_IDX_SHARP2: sharpen_limit_second <= wd;
					`JCBC_IDX_LAUNCH: begin
						// both bits in one write pulse together; the engine settles which wins
						codec_launch <= wd[`JCBC_BIT_LAUNCH];
						engine_soft_reset <= wd[`JCBC_BIT_SOFT_RST];
					end
					// only the direction bit takes writes; the state field is live
					`JCBC_IDX_STATE: direction_select <= wd[`JCBC_BIT_DIR];
					`JCBC_IDX_FLAGS: begin
						// answer only matters while the engine waits on it
						if (flags_ff[`JCBC_BIT_SIZE]) begin
							size_continue <= wd[`JCBC_BIT_SIZE];
							size_stop <= ~wd[`JCBC_BIT_SIZE];
						end
						if (flags_ff[`JCBC_BIT_FAULT]) begin
							fault_continue <= wd[`JCBC_BIT_FAULT];
							fault_stop <= ~wd[`JCBC_BIT_FAULT];
						end
					end
					default: ;
				endcase
			end
		end
	end

endmodule // jcbc_ctrl
`default_nettype wire

// ==== sim/jcbc_ctrl_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module jcbc_ctrl_monitor (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// configuration and commands
	input wire logic [4:0] line_buffer_slice_count,
	input wire logic [4:0] chroma_slice_count,
	input wire logic direction_select,
	input wire logic encode_trigger_source,
	input wire logic luma_from_isp,
	input wire logic code_written_by_engine,
	input wire logic codec_launch,
	input wire logic engine_soft_reset
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
ready_rise_a: assert property (psel && penable && pce && !pready |=> pready) else $error("pready late");
ready_single_a: assert property (pready |=> !pready) else $error("pready held");
upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("prdata upper set");
misalign_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr) else $error("no slave error");
launch_cause_a: assert property (codec_launch == $past(psel && pready && pwrite && paddr == 14'h2ab8 && pwdata[8])) else $error("launch pulse wrong");
soft_reset_cause_a: assert property (engine_soft_reset == $past(psel && pready && pwrite && paddr == 14'h2ab8 && pwdata[0])) else $error("soft reset pulse wrong");
slice_max_a: assert property (line_buffer_slice_count <= 5'h10) else $error("slice count above max");
chroma_half_a: assert property (chroma_slice_count == $past(line_buffer_slice_count) >> 1) else $error("chroma slices");
code_dir_a: assert property (code_written_by_engine == $past(direction_select)) else $error("code direction");
isp_source_a: assert property (luma_from_isp == $past(direction_select && !encode_trigger_source)) else $error("luma source");
endmodule // jcbc_ctrl_monitor
`default_nettype wire

// ==== sim/jcbc_eng_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module jcbc_eng_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// commands
	input wire logic codec_launch,
	input wire logic engine_soft_reset,
	input wire logic direction_select,
	// bench requests: size, fault
	input wire logic [1:0] evt_req,
	// engine status
	output logic [3:0] eng_state,
	output logic eng_size_evt,
	output logic eng_fault_evt,
	output logic eng_enc_done_evt,
	output logic eng_dec_done_evt
);
// short fixed run length keeps the bench fast; a real engine runs far longer
logic [4:0] cnt_ff;
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cnt_ff <= 5'h00;
		eng_state <= 4'h0;
		{eng_size_evt, eng_fault_evt, eng_enc_done_evt, eng_dec_done_evt} <= 4'h0;
	end else begin
		{eng_size_evt, eng_fault_evt} <= evt_req;
		eng_enc_done_evt <= 1'h0;
		eng_dec_done_evt <= 1'h0;
		if (engine_soft_reset) begin
			cnt_ff <= 5'h00;
			eng_state <= 4'h0;
		end else if (codec_launch) begin
			cnt_ff <= 5'h08;
			eng_state <= 4'h1;
		end else if (cnt_ff == 5'h01) begin
			cnt_ff <= 5'h00;
			eng_state <= 4'h0;
			eng_enc_done_evt <= direction_select;
			eng_dec_done_evt <= !direction_select;
		end else if (cnt_ff != 5'h00) begin
			cnt_ff <= cnt_ff - 5'h01;
		end
	end
end
endmodule // jcbc_eng_model
`default_nettype wire

// ==== sim/jcbc_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "jcbc_map.vh"
module jcbc_ctrl_tb_top;
logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, qt_ch, launch, srst, dir, trig, image_signal_processor, irq, ceng;
logic sz_e, ft_e, ed_e, dd_e, sc, ss, fc, fs;
logic [13:0] paddr;
logic [31:0] pwdata, prdata, rdv;
logic [3:0] eng_state, lvl, seen_ff;
logic [18:0] eng_code_valid, csize, amt;
logic [1:0] evt_req;
logic [5:0] qt_a;
logic [7:0] qt_d, rows;
logic [4:0] cs, wsc;
logic [8:0] cols;
logic [21:0] ybase, bbase, rbase, cbase;
logic [10:0] ys, cst;
logic [15:0] sh1, sh2;
int n_errors = 0;
int total_checks = 0;
jcbc_ctrl dut (.pclk(pclk), .presetn(presetn), .pce(1'h1), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .eng_state(eng_state),
	.eng_code_valid(eng_code_valid), .eng_code_full(lvl[3]), .eng_code_empty(lvl[2]), .eng_pix_full(lvl[1]),
	.eng_pix_empty(lvl[0]), .eng_size_evt(sz_e), .eng_fault_evt(ft_e), .eng_enc_done_evt(ed_e),
	.eng_dec_done_evt(dd_e), .eng_slices_seen(5'h03), .qt_rd_chroma(qt_ch), .qt_rd_addr(qt_a), .qt_rd_data(qt_d),
	.luma_block_columns(cols), .luma_block_rows(rows), .luma_buffer_base(ybase), .blue_chroma_buffer_base(bbase),
	.red_chroma_buffer_base(rbase), .line_buffer_slice_count(), .chroma_slice_count(cs), .line_buffer_stride(ys),
	.chroma_line_stride(cst), .written_slice_count(wsc), .code_buffer_base(cbase), .code_buffer_size(csize),
	.code_transfer_amount(amt), .sharpen_limit_first(sh1), .sharpen_limit_second(sh2), .direction_select(dir),
	.encode_trigger_source(trig), .luma_from_isp(image_signal_processor), .code_written_by_engine(ceng), .codec_launch(launch),
	.engine_soft_reset(srst), .size_continue(sc), .size_stop(ss), .fault_continue(fc), .fault_stop(fs), .irq(irq));
jcbc_eng_model u_eng (.pclk(pclk), .presetn(presetn), .codec_launch(launch), .engine_soft_reset(srst),
	.direction_select(dir), .evt_req(evt_req), .eng_state(eng_state), .eng_size_evt(sz_e), .eng_fault_evt(ft_e),
	.eng_enc_done_evt(ed_e), .eng_dec_done_evt(dd_e));
initial begin
	pclk = 1'h0;
	forever #2 pclk = ~pclk;
end
always @(posedge pclk) seen_ff <= presetn ? (seen_ff | {sc, ss, fc, fs}) : 4'h0;
task chk(input logic [31:0] g, e, input string s);
	total_checks++;
	if (g !== e) begin
		n_errors++;
		$display("mismatch %s expected %h seen %h", s, e, g);
	end
endtask
task cyc(input int k);
	repeat (k) @(posedge pclk);
endtask
// entered right after a rising edge; the idle edge at the end keeps back-to-back calls legal
task apb(input logic w, input logic [13:0] a, input logic [15:0] d);
	{psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, 16'h0000, d};
	@(posedge pclk);
	penable <= 1'h1;
	// ends when pready rises; if it never does, only the watchdog ends this wait
	do begin
		@(posedge pclk);
	end while (pready !== 1'h1);
	rdv = prdata;
	err = pslverr;
	{psel, penable} <= 2'h0;
	@(posedge pclk);
endtask
task wr(input logic [11:0] i, input logic [15:0] d);
	apb(1'h1, {i, 2'h0}, d);
endtask
task rc(input logic [11:0] i, input logic [31:0] m, e, input string s);
	apb(1'h0, {i, 2'h0}, 16'h0000);
	chk(rdv & m, e, s);
endtask
task t_regs;
	logic [11:0] ix [18];
	logic [15:0] mk [18];
	ix = '{`JCBC_IDX_COLS, `JCBC_IDX_ROWS, `JCBC_IDX_Y_LO, `JCBC_IDX_Y_HI, `JCBC_IDX_B_HI, `JCBC_IDX_R_HI,
		`JCBC_IDX_Y_STRIDE, `JCBC_IDX_C_STRIDE, `JCBC_IDX_CB_HI, `JCBC_IDX_SZ_HI, `JCBC_IDX_AMT_HI, `JCBC_IDX_IRQ_EN,
		`JCBC_IDX_B_LO, `JCBC_IDX_R_LO, `JCBC_IDX_CB_LO, `JCBC_IDX_AMT_LO, `JCBC_IDX_SHARP1, `JCBC_IDX_SHARP2};
	mk = '{16'h01ff, 16'h00ff, 16'hffff, 16'h003f, 16'h003f, 16'h003f, 16'h07ff, 16'h07ff, 16'h003f, 16'h0307,
		16'h0007, 16'h01ff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
	for (int k = 0; k < 18; k++) begin
		rc(ix[k], 32'hffff_ffff, 32'h0000_0000, "reset");
		wr(ix[k], 16'hffff);
		rc(ix[k], 32'hffff_ffff, {16'h0000, mk[k]}, "mask");
	end
	wr(`JCBC_IDX_SZ_LO, 16'h1234);
	wr(`JCBC_IDX_IRQ_EN, 16'h0000);
	chk(cols, 9'h1ff, "cols");
	chk(ybase, 22'h3f_ffff, "ybase");
	chk(csize, 19'h7_1234, "size");
	chk(rows, 8'hff, "rows");
	chk({ys, cst}, 22'h3f_ffff, "strides");
	chk(bbase, 22'h3f_ffff, "bbase");
	chk(rbase, 22'h3f_ffff, "rbase");
	chk(cbase, 22'h3f_ffff, "cbase");
	chk(amt, 19'h7_ffff, "amount");
	chk({sh1, sh2}, 32'hffff_ffff, "sharpen");
	rc(12'h0a07, 32'h0000_0000, 32'h0000_0000, "unmapped");
	chk(err, 1'h1, "unmapped err");
	apb(1'h1, 14'h2819, 16'h0055);
	chk(err, 1'h1, "align err");
	rc(`JCBC_IDX_COLS, 32'hffff_ffff, 32'h0000_01ff, "refused");
	wr(`JCBC_IDX_SLICES, 16'h001f);
	rc(`JCBC_IDX_SLICES, 32'hffff_ffff, 32'h0000_0010, "clamp");
	wr(`JCBC_IDX_SLICES, 16'h000f);
	cyc(2);
	chk(cs, 5'h07, "chroma");
endtask
task qrd(input logic c, input logic [5:0] a, input logic [7:0] e);
	qt_ch <= c;
	qt_a <= a;
	cyc(2);
	chk(qt_d, e, "quant");
endtask
task t_quant;
	wr(`JCBC_IDX_LQ_FIRST, 16'h2211);
	wr(`JCBC_IDX_CQ_LAST, 16'h4433);
	qrd(1'h0, 6'h00, 8'h11);
	qrd(1'h0, 6'h01, 8'h22);
	qrd(1'h1, 6'h3e, 8'h33);
	qrd(1'h1, 6'h3f, 8'h44);
endtask
task t_trig;
	wr(`JCBC_IDX_WR_SLICES, 16'h0009);
	rc(`JCBC_IDX_WR_SLICES, 32'hffff_ffff, 32'h0000_0003, "slices ro");
	wr(`JCBC_IDX_CTRL, 16'h0008);
	wr(`JCBC_IDX_STATE, 16'h0001);
	chk({dir, trig}, 2'h3, "mode");
	wr(`JCBC_IDX_WR_SLICES, 16'h0009);
	rc(`JCBC_IDX_WR_SLICES, 32'hffff_ffff, 32'h0000_0009, "slices rw");
	chk(wsc, 5'h09, "slices out");
	chk(ceng, 1'h1, "code dir");
	rc(`JCBC_IDX_STATE, 32'hffff_ffff, 32'h0000_0001, "idle");
	wr(`JCBC_IDX_CTRL, 16'h0000);
	cyc(1);
	chk(image_signal_processor, 1'h1, "isp");
endtask
task t_run;
	wr(`JCBC_IDX_IRQ_EN, 16'h0002);
	wr(`JCBC_IDX_LAUNCH, 16'h0100);
	rc(`JCBC_IDX_STATE, 32'hffff_ffff, 32'h0000_0003, "busy");
	for (int k = 0; k < 40 && irq !== 1'h1; k++) @(posedge pclk);
	chk(irq, 1'h1, "irq");
	rc(`JCBC_IDX_FLAGS, 32'hffff_ffff, 32'h0000_0002, "enc done");
	rc(`JCBC_IDX_LAUNCH, 32'hffff_ffff, 32'h0000_0000, "launch reads");
	wr(`JCBC_IDX_IRQ_EN, 16'h0000);
	cyc(1);
	chk(irq, 1'h0, "masked");
	wr(`JCBC_IDX_STATE, 16'h0000);
	wr(`JCBC_IDX_LAUNCH, 16'h0100);
	wr(`JCBC_IDX_LAUNCH, 16'h0001);
	cyc(20);
	rc(`JCBC_IDX_FLAGS, 32'hffff_ffff, 32'h0000_0000, "abort");
	wr(`JCBC_IDX_LAUNCH, 16'h0100);
	cyc(20);
	rc(`JCBC_IDX_FLAGS, 32'hffff_ffff, 32'h0000_0001, "dec done");
endtask
task t_occ;
	wr(`JCBC_IDX_SZ_LO, 16'h0100);
	for (int t = 0; t < 4; t++) begin
		eng_code_valid <= 19'h0_0100 >> (4 - t);
		wr(`JCBC_IDX_SZ_HI, {6'h00, t[1:0], 8'h00});
		wr(`JCBC_IDX_FLAGS, 16'h0100);
		rc(`JCBC_IDX_FLAGS, 32'h0000_0100, 32'h0000_0000, "at limit");
		eng_code_valid <= eng_code_valid + 19'h0_0001;
		cyc(2);
		rc(`JCBC_IDX_FLAGS, 32'h0000_0100, 32'h0000_0100, "over limit");
	end
	eng_code_valid <= 19'h0_0000;
	wr(`JCBC_IDX_FLAGS, 16'h0000);
	rc(`JCBC_IDX_FLAGS, 32'h0000_0100, 32'h0000_0100, "sticky");
	wr(`JCBC_IDX_IRQ_EN, 16'h0100);
	cyc(1);
	chk(irq, 1'h1, "occ irq");
	wr(`JCBC_IDX_FLAGS, 16'h0100);
	rc(`JCBC_IDX_FLAGS, 32'h0000_0100, 32'h0000_0000, "cleared");
	wr(`JCBC_IDX_IRQ_EN, 16'h0000);
endtask
task pulse(input logic [1:0] e);
	evt_req <= e;
	cyc(1);
	evt_req <= 2'h0;
	cyc(2);
endtask
task t_evt;
	for (int k = 0; k < 2; k++) begin
		lvl <= 4'ha >> k;
		cyc(2);
		rc(`JCBC_IDX_FLAGS, 32'h0000_00f0, {24'h00_0000, 4'ha >> k, 4'h0}, "level");
	end
	lvl <= 4'h0;
	pulse(2'h2);
	rc(`JCBC_IDX_FLAGS, 32'h0000_000c, 32'h0000_0008, "size flag");
	wr(`JCBC_IDX_FLAGS, 16'h0008);
	rc(`JCBC_IDX_FLAGS, 32'h0000_000c, 32'h0000_0000, "resumed");
	pulse(2'h1);
	rc(`JCBC_IDX_FLAGS, 32'h0000_000c, 32'h0000_0004, "fault flag");
	wr(`JCBC_IDX_FLAGS, 16'h0000);
	rc(`JCBC_IDX_FLAGS, 32'h0000_000c, 32'h0000_0000, "stopped");
	chk(seen_ff, 4'h9, "pulses");
endtask
task close_out;
	if (n_errors == 0 && total_checks > 0) begin
		$display("Regression OK");
	end else begin
		$display("Regression broken");
	end
	$finish;
endtask
initial begin
	{presetn, psel, penable, pwrite, paddr, pwdata, eng_code_valid, lvl, evt_req, qt_ch, qt_a} = '0;
	cyc(16);
	presetn <= 1'h1;
	cyc(1);
	t_regs;
	t_quant;
	t_trig;
	t_run;
	t_occ;
	t_evt;
	close_out;
end
initial begin
	#(20000 * 4);
	n_errors++;
	close_out;
end
endmodule // jcbc_ctrl_tb_top
bind jcbc_ctrl jcbc_ctrl_monitor u_mon (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.line_buffer_slice_count(line_buffer_slice_count), .chroma_slice_count(chroma_slice_count),
	.direction_select(direction_select), .encode_trigger_source(encode_trigger_source),
	.luma_from_isp(luma_from_isp), .code_written_by_engine(code_written_by_engine), .codec_launch(codec_launch),
	.engine_soft_reset(engine_soft_reset));
`default_nettype wire
